// ==== pcs_pkg.sv ====
// Shared constants, register map and carrier types for the current sampler
package pcs_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DW = 16;
  localparam int AW = 12;
  localparam int CW = 14;

  // ---------------------------------------------------------------
  // Timing: 96 MHz tick made from the 125 MHz bus clock
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int TICK_MHZ       = 96;
  localparam int TICK_PS        = 10417;
  localparam int PCLK_OFS_PS    = 41668;
  localparam logic [15:0] PCLK_OFS_TICKS = 16'((PCLK_OFS_PS + TICK_PS - 1) / TICK_PS);

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_GUARD  = 8'h04;
  localparam logic [7:0] A_DELAY  = 8'h08;
  localparam logic [7:0] A_MINP   = 8'h0c;
  localparam logic [7:0] A_PERIOD = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_POINTS = 8'h18;
  localparam logic [7:0] A_CUR_UV = 8'h1c;
  localparam logic [7:0] A_CUR_W  = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int B_EN     = 0;
  localparam int B_SINGLE = 1;
  localparam int B_THREE  = 2;
  localparam int B_MINP   = 3;
  localparam int B_OVR    = 3;

  // ---------------------------------------------------------------
  // Reset values (in ticks)
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_PERIOD = 16'h12c0;
  localparam logic [15:0] RST_GUARD  = 16'h0060;
  localparam logic [15:0] RST_MINP   = 16'h0060;
  localparam logic [15:0] RST_DELAY  = 16'h0000;

  // ---------------------------------------------------------------
  // ADC channel codes and sequencer states
  // ---------------------------------------------------------------
  localparam logic [1:0] CH_U  = 2'h0;
  localparam logic [1:0] CH_V  = 2'h1;
  localparam logic [1:0] CH_W  = 2'h2;
  localparam logic [1:0] CH_SH = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_WAIT1 = 3'b001,
    S_CONV1 = 3'b010,
    S_WAIT2 = 3'b011,
    S_CONV2 = 3'b100,
    S_CONV3 = 3'b101,
    S_DONE  = 3'b110
  } pcs_state_t;

  typedef struct packed {
    logic minp;
    logic three;
    logic single;
    logic en;
  } pcs_cfg_t;

  typedef struct packed {
    logic [DW-1:0] u;
    logic [DW-1:0] v;
    logic [DW-1:0] w;
  } pcs_duty_t;

  typedef struct packed {
    logic signed [CW-1:0] u;
    logic signed [CW-1:0] v;
    logic signed [CW-1:0] w;
  } pcs_cur_t;

endpackage

// ==== pcs_tick_gen.sv ====
// Fractional divider giving one-cycle tick enables at the timing rate
`timescale 1ns/10ps
`default_nettype none
module pcs_tick_gen #(
  parameter int INC = 96,
  parameter int MOD = 125
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Tick enable
  output var  logic tick
);
  generate
    if (INC < 1 || INC >= MOD || MOD > 255) begin : g_bad
      $error("pcs_tick_gen: INC must lie in 1..MOD-1, MOD at most 255");
    end
  endgenerate

  localparam logic [8:0] INC9 = 9'(INC);
  localparam logic [8:0] MOD9 = 9'(MOD);

  logic [8:0] acc_ff;
  logic [8:0] nxt_acc;

  assign nxt_acc = acc_ff + INC9;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 9'h000;
      tick   <= 1'b0;
    end else if (nxt_acc >= MOD9) begin
      acc_ff <= nxt_acc - MOD9;
      tick   <= 1'b1;
    end else begin
      acc_ff <= nxt_acc;
      tick   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== pcs_phase_map.sv ====
// Sector decode: which phase leads, which trails, and their on-times
`timescale 1ns/10ps
`default_nettype none
module pcs_phase_map (
  // Inputs
  input  wire logic [2:0]         sector,
  input  wire pcs_pkg::pcs_duty_t duty,
  // Ordered on-times
  output var  logic [1:0]         hi_idx,
  output var  logic [1:0]         lo_idx,
  output var  logic [15:0]        d_hi,
  output var  logic [15:0]        d_mid,
  output var  logic [15:0]        d_lo
);
  import pcs_pkg::*;

  function automatic logic [15:0] pick(input pcs_duty_t d, input logic [1:0] i);
    return (i == 2'h0) ? d.u : (i == 2'h1) ? d.v : d.w;
  endfunction

  always_comb begin
    unique case (sector)
      3'h2:    begin hi_idx = 2'h1; lo_idx = 2'h2; end
      3'h3:    begin hi_idx = 2'h1; lo_idx = 2'h0; end
      3'h4:    begin hi_idx = 2'h2; lo_idx = 2'h0; end
      3'h5:    begin hi_idx = 2'h2; lo_idx = 2'h1; end
      3'h6:    begin hi_idx = 2'h0; lo_idx = 2'h1; end
      default: begin hi_idx = 2'h0; lo_idx = 2'h2; end
    endcase
    d_hi  = pick(duty, hi_idx);
    d_lo  = pick(duty, lo_idx);
    d_mid = pick(duty, 2'h3 - hi_idx - lo_idx);
  end
endmodule
`default_nettype wire

// ==== pcs_sampler.sv ====
// PWM-synchronous phase current sampler with AHB-Lite register slave
// Functional notes
// - Fresh phase current set every PWM cycle
// - Leg-shunt or single DC-link shunt configurations
// - Two-phase leg: sample U,V; W negative sum
// - Three-phase leg: sample U, V and W
// - Leg samples inside low zero vector
// - Guard band caps leg on-time at period minus guard
// - Leg U sample at delay plus four ticks
// - Signed sample delay in ticks
// - Leg V sample right after U completes
// - Shunt: one sample per active vector, sector map
// - First shunt sample mid vector plus delay
// - Second shunt sample mid vector plus delay
// - Late sample points pulled before cycle end
// - Shunt: minimum pulse lengthens short active vectors
// - Minimum pulse moves sample points to mid of lengthened vectors
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pcs_sampler (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic [2:0]         hsize,
  input  wire logic               hwrite,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output var  logic               hreadyout,
  output var  logic               hresp,
  output var  logic [31:0]        hrdata,
  // PWM generator
  input  wire pcs_pkg::pcs_duty_t duty_req,
  input  wire logic [2:0]         sector,
  output var  pcs_pkg::pcs_duty_t duty_out,
  output var  logic               cycle_start,
  // ADC
  output var  logic               adc_start,
  output var  logic [1:0]         adc_chan,
  input  wire logic               adc_done,
  input  wire logic [11:0]        adc_result,
  // Control loop
  output var  pcs_pkg::pcs_cur_t  cur,
  output var  logic               cur_valid,
  output var  logic [15:0]        first_sense_point,
  output var  logic [15:0]        second_sense_point
);
  import pcs_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [15:0] usub(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : 16'h0000;
  endfunction

  function automatic logic [15:0] clampp(input logic signed [17:0] p,
                                         input logic [15:0] lim);
    if (p < 0)
      return 16'h0000;
    else if (p > $signed({2'b00, lim}))
      return lim;
    else
      return p[15:0];
  endfunction

  function automatic pcs_cur_t recon(input pcs_cfg_t c, input logic [1:0] hi,
                                     input logic [1:0] lo, input logic signed [11:0] a,
                                     input logic signed [11:0] b,
                                     input logic signed [11:0] w);
    logic signed [13:0] ax;
    logic signed [13:0] bx;
    logic signed [13:0] wx;
    logic signed [13:0] r [3];
    pcs_cur_t           o;
    ax = 14'(a);
    bx = 14'(b);
    wx = 14'(w);
    if (c.single) begin
      r[0] = bx - ax;
      r[1] = bx - ax;
      r[2] = bx - ax;
      r[hi] = ax;
      r[lo] = -bx;
    end else begin
      r[0] = ax;
      r[1] = bx;
      r[2] = c.three ? wx : -(ax + bx);
    end
    o.u = r[0];
    o.v = r[1];
    o.w = r[2];
    return o;
  endfunction

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  pcs_cfg_t           ctrl_ff;
  pcs_cfg_t           cfg_ff;
  logic [15:0]        guard_ff;
  logic signed [15:0] delay_ff;
  logic [15:0]        minp_ff;
  logic [15:0]        period_ff;
  logic               overrun_ff;
  logic [7:0]         addr_ff;
  logic               wr_ff;
  logic [15:0]        cnt_ff;
  logic [2:0]         sector_ff;
  logic [1:0]         hi_idx_ff;
  logic [1:0]         lo_idx_ff;
  logic signed [11:0] s1_ff;
  logic signed [11:0] s2_ff;
  pcs_state_t         state_ff;
  pcs_state_t         nxt_state;
  logic               nxt_start;
  logic [1:0]         nxt_chan;
  logic               fin;
  logic               ovr_set;
  logic               tick;
  logic               cyc;
  logic               acc_rd;
  logic [31:0]        rd_mux;
  logic [15:0]        lim_leg;
  logic [15:0]        lim_ss;
  logic [15:0]        cap;
  pcs_duty_t          dcl;
  pcs_duty_t          nxt_duty;
  logic [1:0]         hi_idx;
  logic [1:0]         lo_idx;
  logic [15:0]        d_hi;
  logic [15:0]        d_mid;
  logic [15:0]        d_lo;
  logic [15:0]        hi2;
  logic [15:0]        lo2;
  logic [16:0]        two_min;
  logic [16:0]        hi_sum;
  logic [15:0]        t1n;
  logic [15:0]        t2n;
  logic signed [17:0] p1;
  logic signed [17:0] p2;
  logic [15:0]        legp;
  logic [15:0]        nxt_pt1;
  logic [15:0]        nxt_pt2;

  // ---------------------------------------------------------------
  // Tick base and sector decode
  // ---------------------------------------------------------------
  pcs_tick_gen #(.INC(TICK_MHZ), .MOD(CLK_MHZ)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  assign dcl.u = umin(duty_req.u, period_ff);
  assign dcl.v = umin(duty_req.v, period_ff);
  assign dcl.w = umin(duty_req.w, period_ff);

  pcs_phase_map u_map (
    .sector (sector),
    .duty   (dcl),
    .hi_idx (hi_idx),
    .lo_idx (lo_idx),
    .d_hi   (d_hi),
    .d_mid  (d_mid),
    .d_lo   (d_lo)
  );

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  assign acc_rd = hready && hsel && htrans[1] && !hwrite;

  always_comb begin
    unique case (haddr[7:0])
      A_CTRL:   rd_mux = {28'h0, ctrl_ff};
      A_GUARD:  rd_mux = {16'h0, guard_ff};
      A_DELAY:  rd_mux = {16'h0, delay_ff};
      A_MINP:   rd_mux = {16'h0, minp_ff};
      A_PERIOD: rd_mux = {16'h0, period_ff};
      A_STATUS: rd_mux = {24'h0, state_ff, 1'b0, overrun_ff, sector_ff};
      A_POINTS: rd_mux = {second_sense_point, first_sense_point};
      A_CUR_UV: rd_mux = {2'h0, cur.v, 2'h0, cur.u};
      A_CUR_W:  rd_mux = {18'h0, cur.w};
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff     <= 1'b0;
      addr_ff   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_ff     <= hready && hsel && htrans[1] && hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && hsel && htrans[1])
        addr_ff <= haddr[7:0];
      if (acc_rd)
        hrdata <= rd_mux;
    end
  end

  // Software settings; mode bits only change while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff   <= '0;
      guard_ff  <= RST_GUARD;
      delay_ff  <= RST_DELAY;
      minp_ff   <= RST_MINP;
      period_ff <= RST_PERIOD;
    end else if (wr_ff) begin
      unique case (addr_ff)
        A_CTRL: begin
          ctrl_ff.en <= hwdata[B_EN];
          if (!ctrl_ff.en) begin
            ctrl_ff.single <= hwdata[B_SINGLE];
            ctrl_ff.three  <= hwdata[B_THREE];
            ctrl_ff.minp   <= hwdata[B_MINP];
          end
        end
        A_GUARD:  guard_ff  <= hwdata[15:0];
        A_DELAY:  delay_ff  <= hwdata[15:0];
        A_MINP:   minp_ff   <= hwdata[15:0];
        A_PERIOD: period_ff <= hwdata[15:0];
        default:  ;
      endcase
    end
  end

  // Sticky overrun: a new set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      overrun_ff <= 1'b0;
    else if (ovr_set)
      overrun_ff <= 1'b1;
    else if (wr_ff && addr_ff == A_STATUS && hwdata[B_OVR])
      overrun_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // PWM timebase in ticks
  // ---------------------------------------------------------------
  assign lim_leg = usub(period_ff, 16'h0001);
  assign lim_ss  = usub(period_ff, 16'h0002);
  assign cyc     = ctrl_ff.en && tick && (cnt_ff >= lim_leg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff      <= 16'h0000;
      cycle_start <= 1'b0;
    end else begin
      cycle_start <= cyc;
      if (!ctrl_ff.en)
        cnt_ff <= 16'h0000;
      else if (tick)
        cnt_ff <= cyc ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Per-cycle on-time limits and sample points
  // ---------------------------------------------------------------
  always_comb begin
    cap     = usub(period_ff, guard_ff);
    two_min = {minp_ff, 1'b0};
    hi_sum  = {1'b0, d_mid} + two_min;
    hi2     = d_hi;
    lo2     = d_lo;
    if (ctrl_ff.minp && (usub(d_hi, d_mid) >> 1) < minp_ff)
      hi2 = (hi_sum > {1'b0, period_ff}) ? period_ff : hi_sum[15:0];
    if (ctrl_ff.minp && (usub(d_mid, d_lo) >> 1) < minp_ff)
      lo2 = ({1'b0, d_mid} > two_min) ? d_mid - two_min[15:0] : 16'h0000;
    t1n = usub(hi2, d_mid) >> 1;
    t2n = usub(d_mid, lo2) >> 1;
    p1  = $signed({2'b00, usub(period_ff, hi2) >> 1})
        + $signed({3'b000, t1n[15:1]}) + 18'(delay_ff);
    p2  = $signed({2'b00, usub(period_ff, d_mid) >> 1})
        + $signed({3'b000, t2n[15:1]}) + 18'(delay_ff);
    legp = clampp($signed({2'b00, PCLK_OFS_TICKS}) + 18'(delay_ff), lim_leg);
    if (ctrl_ff.single) begin
      nxt_duty = dcl;
      nxt_pt1  = clampp(p1, lim_ss);
      nxt_pt2  = clampp(p2, lim_ss);
      unique case (hi_idx)
        2'h0:    nxt_duty.u = hi2;
        2'h1:    nxt_duty.v = hi2;
        default: nxt_duty.w = hi2;
      endcase
      unique case (lo_idx)
        2'h0:    nxt_duty.u = lo2;
        2'h1:    nxt_duty.v = lo2;
        default: nxt_duty.w = lo2;
      endcase
    end else begin
      nxt_duty.u = umin(dcl.u, cap);
      nxt_duty.v = umin(dcl.v, cap);
      nxt_duty.w = umin(dcl.w, cap);
      nxt_pt1    = legp;
      nxt_pt2    = legp;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff             <= '0;
      duty_out           <= '0;
      first_sense_point  <= 16'h0000;
      second_sense_point <= 16'h0000;
      sector_ff          <= 3'h0;
      hi_idx_ff          <= 2'h0;
      lo_idx_ff          <= 2'h0;
    end else if (cyc) begin
      cfg_ff             <= ctrl_ff;
      duty_out           <= nxt_duty;
      first_sense_point  <= nxt_pt1;
      second_sense_point <= nxt_pt2;
      sector_ff          <= sector;
      hi_idx_ff          <= hi_idx;
      lo_idx_ff          <= lo_idx;
    end
  end

  // ---------------------------------------------------------------
  // ADC sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    nxt_chan  = adc_chan;
    fin       = 1'b0;
    ovr_set   = cyc && !(state_ff == S_IDLE || state_ff == S_DONE);
    if (!ctrl_ff.en)
      nxt_state = S_IDLE;
    else if (cyc)
      nxt_state = S_WAIT1;
    else begin
      unique case (state_ff)
        S_IDLE, S_DONE: ;
        S_WAIT1:
          if (cnt_ff >= first_sense_point) begin
            nxt_start = 1'b1;
            nxt_chan  = cfg_ff.single ? CH_SH : CH_U;
            nxt_state = S_CONV1;
          end
        S_CONV1:
          if (adc_done) begin
            if (cfg_ff.single)
              nxt_state = S_WAIT2;
            else begin
              nxt_start = 1'b1;
              nxt_chan  = CH_V;
              nxt_state = S_CONV2;
            end
          end
        S_WAIT2:
          if (cnt_ff >= second_sense_point) begin
            nxt_start = 1'b1;
            nxt_chan  = CH_SH;
            nxt_state = S_CONV2;
          end
        S_CONV2:
          if (adc_done) begin
            if (!cfg_ff.single && cfg_ff.three) begin
              nxt_start = 1'b1;
              nxt_chan  = CH_W;
              nxt_state = S_CONV3;
            end else begin
              fin       = 1'b1;
              nxt_state = S_DONE;
            end
          end
        S_CONV3:
          if (adc_done) begin
            fin       = 1'b1;
            nxt_state = S_DONE;
          end
        default: nxt_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff  <= S_IDLE;
      adc_start <= 1'b0;
      adc_chan  <= CH_U;
    end else begin
      state_ff  <= nxt_state;
      adc_start <= nxt_start;
      adc_chan  <= nxt_chan;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= 12'sh000;
      s2_ff <= 12'sh000;
    end else if (adc_done) begin
      if (state_ff == S_CONV1)
        s1_ff <= adc_result;
      if (state_ff == S_CONV2)
        s2_ff <= adc_result;
    end
  end

  // Phase currents latched once the last conversion of the cycle ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur       <= '0;
      cur_valid <= 1'b0;
    end else begin
      cur_valid <= fin;
      if (fin)
        cur <= recon(cfg_ff, hi_idx_ff, lo_idx_ff, s1_ff,
                     (state_ff == S_CONV2) ? adc_result : s2_ff, adc_result);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_leg_cap: assert property (
    cyc && !ctrl_ff.single |=> duty_out.u <= $past(cap) && duty_out.v <= $past(cap)
      && duty_out.w <= $past(cap))
    else $error("leg on-time exceeds period minus guard");
  chk_first_trig: assert property (
    ctrl_ff.en && state_ff == S_WAIT1 && cnt_ff >= first_sense_point && !cyc |=> adc_start
      && adc_chan == (cfg_ff.single ? CH_SH : CH_U) ##1 !adc_start)
    else $error("first sample not triggered at its point");
  chk_v_follows: assert property (
    ctrl_ff.en && state_ff == S_CONV1 && adc_done && !cfg_ff.single && !cyc |=> adc_start
      && adc_chan == CH_V)
    else $error("phase V sample did not follow phase U");
  chk_w_third: assert property (
    ctrl_ff.en && state_ff == S_CONV2 && adc_done && !cfg_ff.single && cfg_ff.three && !cyc
      |=> adc_start && adc_chan == CH_W)
    else $error("third phase not sampled");
  chk_sum_zero: assert property (
    cur_valid && !(cfg_ff.three && !cfg_ff.single) |-> 14'(cur.u + cur.v + cur.w) == 14'h0)
    else $error("derived phase does not close the sum");
  chk_shunt_chan: assert property (
    adc_start && cfg_ff.single |-> adc_chan == CH_SH)
    else $error("shunt mode sampled a leg channel");
  chk_pt_order: assert property (
    cyc && ctrl_ff.single |=> first_sense_point <= second_sense_point)
    else $error("shunt sample points out of order");
  chk_pt_bound: assert property (
    cyc && ctrl_ff.single |=> second_sense_point <= $past(lim_ss))
    else $error("sample point beyond cycle end");
  chk_set_latched: assert property (
    $rose(cur_valid) |-> state_ff == S_DONE ##1 !cur_valid)
    else $error("current set not latched at end of sequence");
  chk_mode_frozen: assert property (
    ctrl_ff.en ##1 ctrl_ff.en |-> $stable(ctrl_ff.single) && $stable(ctrl_ff.three))
    else $error("mode changed while running");

  cov_leg_two: cover property (cur_valid && !cfg_ff.single && !cfg_ff.three);
  cov_leg_three: cover property (cur_valid && !cfg_ff.single && cfg_ff.three);
  cov_single: cover property (cur_valid && cfg_ff.single);
  cov_min_pulse: cover property (cyc && ctrl_ff.single && ctrl_ff.minp && hi2 != d_hi);
endmodule
`default_nettype wire

// ==== pcs_adc_model.sv ====
// Behavioural ADC answering conversion requests after a random delay
`timescale 1ns/10ps
`default_nettype none
module pcs_adc_model (
  // Clock, reset and cycle marker
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        cycle_start,
  // Request and base sample value
  input  wire logic        adc_start,
  input  wire logic [1:0]  adc_chan,
  input  wire logic [11:0] sval,
  // Answer
  output var  logic        adc_done,
  output var  logic [11:0] adc_result
);
  int          seed = 83289;
  int          wait_ff;
  int          n_ff;
  logic [11:0] hold_ff;
  // Result line toggles whenever no result is offered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_done   <= 1'b0;
      adc_result <= 12'h000;
      wait_ff    <= 0;
      n_ff       <= 0;
      hold_ff    <= 12'h000;
    end else begin
      adc_done   <= 1'b0;
      adc_result <= ~adc_result;
      if (cycle_start) begin
        n_ff <= 0;
      end
      if (adc_start) begin
        hold_ff <= sval + 12'(adc_chan) + 12'(64 * (cycle_start ? 0 : n_ff));
        n_ff    <= (cycle_start ? 0 : n_ff) + 1;
        wait_ff <= 1 + ($random(seed) & 15);
      end else if (wait_ff > 0) begin
        wait_ff <= wait_ff - 1;
        if (wait_ff == 1) begin
          adc_done   <= 1'b1;
          adc_result <= hold_ff;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== pcs_sampler_test.sv ====
// Self-checking bench for the phase current sampler
`timescale 1ns/10ps
`default_nettype none
module pcs_sampler_test;
  import pcs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        cycle_start, adc_start, adc_done, cur_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, adc_chan;
  logic [2:0]  hsize, sector;
  logic [11:0] adc_result, sval;
  logic [15:0] first_sense_point, second_sense_point;
  pcs_duty_t   duty_req, duty_out;
  pcs_cur_t    cur;
  int          bad_count, n_compared, seed, cyc, D, mode, s, hi, lo, mi, p1, p2, i, k;
  int          d[3], e[3], a[3], c[3], q[$];
  int          HI[6] = '{0, 1, 1, 2, 2, 0};
  int          LO[6] = '{2, 2, 0, 0, 1, 1};
  int          MODES[4] = '{1, 5, 3, 11};
  int          RA[6] = '{0, 4, 8, 12, 16, 64};
  int          RV[6] = '{0, 96, 0, 96, 4800, 0};
  assign hready = hreadyout;
  pcs_sampler u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hsize, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .duty_req, .sector, .duty_out, .cycle_start,
    .adc_start, .adc_chan, .adc_done, .adc_result, .cur, .cur_valid,
    .first_sense_point, .second_sense_point);
  pcs_adc_model u_adc (.hclk, .hresetn, .cycle_start, .adc_start, .adc_chan, .sval,
    .adc_done, .adc_result);
  // ----
  // Tasks
  // ----
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input int ad, input int wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(ad);
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= 32'(wd);
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function int sx(int x);
    return int'($signed(12'(x)));
  endfunction
  function int clamp(int x, int hi_lim);
    return x < 0 ? 0 : (x > hi_lim ? hi_lim : x);
  endfunction
  // ----
  // Stimulus
  // ----
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, duty_req, sval} = '0;
    hsize = 3'h2;
    sector = 3'h1;
    seed = 83289;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      ahb(0, RA[i], 0);
      chk(rd, 48'(RV[i]));
      chk(48'(hresp), 48'h0);
    end
    ahb(1, 4, 16);
    ahb(1, 12, 8);
    ahb(1, 16, 128);
    for (i = 0; i < 24; i++) begin
      mode = MODES[i / 6];
      D = $random(seed) % 9;
      s = 1 + ($random(seed) & 32'h7fff) % 6;
      q = {$random(seed) & 127, $random(seed) & 127, $random(seed) & 127};
      q.sort();
      hi = HI[s - 1];
      lo = LO[s - 1];
      mi = 3 - hi - lo;
      d[hi] = q[2];
      d[mi] = q[1];
      d[lo] = q[0];
      ahb(1, 0, 0);
      ahb(1, 8, D);
      duty_req <= {16'(d[0]), 16'(d[1]), 16'(d[2])};
      sector <= 3'(s);
      sval <= 12'($random(seed));
      ahb(1, 0, mode);
      ahb(1, 0, mode ^ 2);
      ahb(0, 0, 0);
      chk(rd, 48'(mode));
      e = d;
      for (k = 0; k < 3; k++) if (!mode[1] && e[k] > 112) e[k] = 112;
      if (mode[3] && (e[hi] - e[mi]) / 2 < 8) e[hi] = e[mi] + 16 > 128 ? 128 : e[mi] + 16;
      if (mode[3] && (e[mi] - e[lo]) / 2 < 8) e[lo] = e[mi] - 16 < 0 ? 0 : e[mi] - 16;
      p1 = clamp((128 - e[hi]) / 2 + ((e[hi] - e[mi]) / 2) / 2 + D, 126);
      p2 = clamp((128 - e[mi]) / 2 + ((e[mi] - e[lo]) / 2) / 2 + D, 126);
      if (!mode[1]) p1 = clamp(4 + D, 127);
      repeat (2) do @(posedge hclk); while (cycle_start !== 1'b1);
      chk(duty_out, {16'(e[0]), 16'(e[1]), 16'(e[2])});
      chk(first_sense_point, 48'(p1));
      if (mode[1]) chk(second_sense_point, 48'(p2));
      do @(posedge hclk); while (cur_valid !== 1'b1);
      for (k = 0; k < 3; k++) a[k] = sx(sval + (mode[1] ? 3 : k) + 64 * k);
      c = '{a[0], a[1], mode[2] ? a[2] : -(a[0] + a[1])};
      if (mode[1]) begin
        c[hi] = a[0];
        c[lo] = -a[1];
        c[mi] = a[1] - a[0];
      end
      chk(cur, {14'(c[0]), 14'(c[1]), 14'(c[2])});
      ahb(0, 28, 0);
      chk(rd, 48'({2'h0, 14'(c[1]), 2'h0, 14'(c[0])}));
      $display("test %0d mode %0d sector %0d done", i, mode, s);
    end
    // Corner: points pushed past the cycle end are pulled back, late sample overruns
    ahb(1, 8, 200);
    repeat (3) do @(posedge hclk); while (cycle_start !== 1'b1);
    chk(first_sense_point, 48'd126);
    chk(second_sense_point, 48'd126);
    ahb(0, 24, 0);
    chk(rd, 48'h007e_007e);
    ahb(0, 20, 0);
    chk(48'(rd[3]), 48'h1);
    $display("test corner late point done");
    finish_test();
  end
endmodule
`default_nettype wire
